//--- logic/lpra_top.v
/*
  Logic probe response and stimulus block: event counter, level history,
  gated signature, snapshot into result register zero, stimulus pulses.
  Assumes threshold comparators and the pod sync pulse arrive unsynchronised;
  mode, snapshot and stimulus selects come from logic on i_clk.
*/
// Function
// - Snapshot loads gathered data into result zero
// - Event counter is seven bits, circular
// - Snapshot reports count, then restarts from zero
// - Counter wraps after 127, keeps counting
// - Events counted in every sync mode
// - Count only when leaving the high level
// - Low/invalid toggling never counts
// - Sticky high, invalid, low flags reported
// - Synced modes record levels only while valid
// - Free-run records levels at all times
// - Synced modes never set the invalid flag
// - Signature from valid-period samples; none free-run
// - Synced: one stimulus pulse per valid period
// - Free-run: 2 us pulses at 1 kHz
// - Snapshot itself causes no stimulus
// - Response sees all tip activity, own pulses too
// - Indicators gated by valid period when synced
// - Any mode selection clears accumulated data
// - Free-run mode after reset
// - Signature is a 16-bit cyclic check
`timescale 1ns/1ps
`default_nettype none
`include "lpra_consts.vh"

module lpra_top #(
  parameter [`LPRA_TMR_W-1:0] P_STIM_PERIOD_CYC = `LPRA_STIM_PERIOD_CYC
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // Tip comparators and pod sync, asynchronous
  input wire i_tip_above_hi,
  input wire i_tip_below_lo,
  input wire i_sync_valid,
  // Instrument control
  input wire i_snap,
  input wire i_mode_sel,
  input wire [`LPRA_MODE_W-1:0] i_mode,
  input wire i_stim_hi_sel,
  input wire i_stim_lo_sel,
  // Results
  output wire [`LPRA_RES_W-1:0] o_result0,
  output wire o_snap_done,
  output wire [`LPRA_MODE_W-1:0] o_mode,
  // Indicators
  output wire o_ind_hi,
  output wire o_ind_lo,
  // Tip drive
  output wire o_tip_out,
  output wire o_tip_oe
);

  // ----------------------------------------
  // Local constants
  // ----------------------------------------
  localparam [`LPRA_TMR_W-1:0] STIM_W_CYC = `LPRA_STIM_WIDTH_CYC;
  localparam [`LPRA_TMR_W-1:0] TMR_ZERO = 18'h00000;
  localparam [`LPRA_TMR_W-1:0] TMR_ONE = 18'h00001;
  localparam [`LPRA_CNT_W-1:0] CNT_ONE = 7'h01;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_FREE = 3'h2;
  localparam [2:0] ST_SYNC = 3'h4;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Level reporting is allowed in free-run, or in a valid period
  function gate_ok;
    input [`LPRA_MODE_W-1:0] mode;
    input valid;
    begin
      gate_ok = (mode == `LPRA_MODE_FREE) | valid;
    end
  endfunction

  function is_synced;
    input [`LPRA_MODE_W-1:0] mode;
    begin
      is_synced = (mode == `LPRA_MODE_ADDR) | (mode == `LPRA_MODE_DATA);
    end
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [1:0] hi_sync_reg;
  reg [1:0] lo_sync_reg;
  reg [1:0] sv_sync_reg;
  reg hi_prev_reg;
  reg sv_prev_reg;

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hi_sync_reg <= 2'h0;
      lo_sync_reg <= 2'h0;
      sv_sync_reg <= 2'h0;
      hi_prev_reg <= 1'b0;
      sv_prev_reg <= 1'b0;
    end else begin
      // Comparators watched even while we drive the tip
      hi_sync_reg <= {hi_sync_reg[0], i_tip_above_hi};
      lo_sync_reg <= {lo_sync_reg[0], i_tip_below_lo};
      sv_sync_reg <= {sv_sync_reg[0], i_sync_valid};
      hi_prev_reg <= hi_sync_reg[1];
      sv_prev_reg <= sv_sync_reg[1];
    end
  end

  // ----------------------------------------
  // Level decode
  // ----------------------------------------
  wire lvl_hi;
  wire lvl_lo;
  wire lvl_inv;
  wire sv;
  wire sv_fall;
  wire sv_rise;
  wire ev_fall;

  // High wins if both comparators claim the tip
  assign lvl_hi = hi_sync_reg[1];
  assign lvl_lo = lo_sync_reg[1] & ~hi_sync_reg[1];
  assign lvl_inv = ~hi_sync_reg[1] & ~lo_sync_reg[1];
  assign sv = sv_sync_reg[1];
  assign sv_rise = sv & ~sv_prev_reg;
  assign sv_fall = ~sv & sv_prev_reg;
  // Only a drop out of high counts; ungated by mode
  assign ev_fall = hi_prev_reg & ~hi_sync_reg[1];

  // ----------------------------------------
  // Mode register
  // ----------------------------------------
  reg [`LPRA_MODE_W-1:0] mode_reg;
  reg [`LPRA_MODE_W-1:0] mode_next;
  wire synced;

  always @* begin
    mode_next = mode_reg;
    if (i_mode_sel) begin
      // Unknown codes fall back to free-run
      if (is_synced(i_mode)) begin
        mode_next = i_mode;
      end else begin
        mode_next = `LPRA_MODE_FREE;
      end
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_reg <= `LPRA_MODE_RST;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign synced = is_synced(mode_reg);

  // ----------------------------------------
  // Accumulators
  // ----------------------------------------
  reg [`LPRA_CNT_W-1:0] cnt_reg;
  reg [`LPRA_CNT_W-1:0] cnt_next;
  reg [`LPRA_CNT_W-1:0] cnt_upd;
  reg seen_hi_reg;
  reg seen_inv_reg;
  reg seen_lo_reg;
  reg seen_hi_next;
  reg seen_inv_next;
  reg seen_lo_next;
  reg seen_hi_upd;
  reg seen_inv_upd;
  reg seen_lo_upd;
  wire acc_clr;
  wire rec_gate;
  wire sig_shift;
  wire [`LPRA_SIG_W-1:0] sig_val;

  // Mode selection, even the same mode, drops history
  assign acc_clr = i_mode_sel | i_snap;
  assign rec_gate = gate_ok(mode_reg, sv);
  // One sample per valid period, its last one inside it
  assign sig_shift = synced & sv_fall;

  always @* begin
    // Natural 7-bit overflow wraps 127 to zero
    cnt_upd = cnt_reg + (ev_fall ? CNT_ONE : `LPRA_CNT_RST);
    seen_hi_upd = seen_hi_reg | (rec_gate & lvl_hi);
    seen_lo_upd = seen_lo_reg | (rec_gate & lvl_lo);
    // Invalid is never logged in a synced mode
    seen_inv_upd = seen_inv_reg | (~synced & lvl_inv);
    cnt_next = cnt_upd;
    seen_hi_next = seen_hi_upd;
    seen_lo_next = seen_lo_upd;
    seen_inv_next = seen_inv_upd;
    if (acc_clr) begin
      // Restart from zero after a report
      cnt_next = `LPRA_CNT_RST;
      seen_hi_next = 1'b0;
      seen_lo_next = 1'b0;
      seen_inv_next = 1'b0;
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= `LPRA_CNT_RST;
      seen_hi_reg <= 1'b0;
      seen_inv_reg <= 1'b0;
      seen_lo_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      seen_hi_reg <= seen_hi_next;
      seen_inv_reg <= seen_inv_next;
      seen_lo_reg <= seen_lo_next;
    end
  end

  lpra_sig u_sig (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_clr(acc_clr),
    .i_shift(sig_shift),
    .i_bit(hi_prev_reg),
    .o_sig(sig_val)
  );

  // ----------------------------------------
  // Snapshot into result zero
  // ----------------------------------------
  reg [`LPRA_RES_W-1:0] res_reg;
  reg snap_done_reg;
  wire [`LPRA_SIG_W-1:0] sig_rep;

  // Free-run reports a zero signature
  assign sig_rep = synced ? sig_val : `LPRA_SIG_RST;

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      res_reg <= `LPRA_RES_RST;
      snap_done_reg <= 1'b0;
    end else begin
      snap_done_reg <= i_snap;
      if (i_snap) begin
        // Includes an event landing in the snapshot cycle
        res_reg <= {sig_rep, seen_hi_upd, seen_inv_upd, seen_lo_upd, cnt_upd};
      end
    end
  end

  // ----------------------------------------
  // Indicators
  // ----------------------------------------
  reg ind_hi_reg;
  reg ind_lo_reg;

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ind_hi_reg <= 1'b0;
      ind_lo_reg <= 1'b0;
    end else begin
      // Lamp persistence lives outside this block
      ind_hi_reg <= rec_gate & lvl_hi;
      ind_lo_reg <= rec_gate & lvl_lo;
    end
  end

  // ----------------------------------------
  // Stimulus generator
  // ----------------------------------------
  reg [2:0] st_reg;
  reg [2:0] st_next;
  reg [`LPRA_TMR_W-1:0] per_reg;
  reg [`LPRA_TMR_W-1:0] per_next;
  reg [`LPRA_TMR_W-1:0] wid_reg;
  reg [`LPRA_TMR_W-1:0] wid_next;
  reg alt_reg;
  reg alt_next;
  reg drv_oe_reg;
  reg drv_oe_next;
  reg drv_val_reg;
  reg drv_val_next;
  wire stim_en;
  wire pol;

  assign stim_en = i_stim_hi_sel | i_stim_lo_sel;
  // Both selects alternate; one select fixes polarity
  assign pol = (i_stim_hi_sel & i_stim_lo_sel) ? alt_reg : i_stim_hi_sel;

  always @* begin
    st_next = st_reg;
    wid_next = wid_reg;
    alt_next = alt_reg;
    // Free-running 1 kHz frame, restarted by a mode change
    if (i_mode_sel || per_reg == P_STIM_PERIOD_CYC - TMR_ONE) begin
      per_next = TMR_ZERO;
    end else begin
      per_next = per_reg + TMR_ONE;
    end
    case (st_reg)
      ST_IDLE: begin
        // Snapshot requests never start a pulse
        if (stim_en && !synced && per_reg == TMR_ZERO) begin
          st_next = ST_FREE;
          wid_next = TMR_ZERO;
        end else if (stim_en && synced && sv_rise) begin
          st_next = ST_SYNC;
        end
      end
      ST_FREE: begin
        wid_next = wid_reg + TMR_ONE;
        if (wid_reg == STIM_W_CYC - TMR_ONE) begin
          st_next = ST_IDLE;
          alt_next = ~alt_reg;
        end
      end
      ST_SYNC: begin
        // Pulse lasts exactly the valid period
        if (!sv) begin
          st_next = ST_IDLE;
          alt_next = ~alt_reg;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
    // Mode change or deselect aborts any pulse in flight
    if (i_mode_sel || !stim_en) begin
      st_next = ST_IDLE;
    end
    drv_oe_next = (st_next != ST_IDLE);
    drv_val_next = drv_oe_next & pol;
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg <= ST_IDLE;
      per_reg <= TMR_ZERO;
      wid_reg <= TMR_ZERO;
      alt_reg <= 1'b1;
      drv_oe_reg <= 1'b0;
      drv_val_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      per_reg <= per_next;
      wid_reg <= wid_next;
      alt_reg <= alt_next;
      drv_oe_reg <= drv_oe_next;
      drv_val_reg <= drv_val_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_result0 = res_reg;
  assign o_snap_done = snap_done_reg;
  assign o_mode = mode_reg;
  assign o_ind_hi = ind_hi_reg;
  assign o_ind_lo = ind_lo_reg;
  assign o_tip_out = drv_val_reg;
  assign o_tip_oe = drv_oe_reg;

endmodule // lpra_top
`default_nettype wire

//--- inc/lpra_consts.vh
/*
  Constants for the logic probe response accumulator: sync mode codes,
  result word layout, stimulus timing and signature taps.
  Assumes a 250 MHz core clock feeding every timing count.
*/
`ifndef LPRA_CONSTS_VH
`define LPRA_CONSTS_VH

// ----------------------------------------
// Sync mode codes
// ----------------------------------------
`define LPRA_MODE_W 2
`define LPRA_MODE_FREE 2'h0
`define LPRA_MODE_ADDR 2'h1
`define LPRA_MODE_DATA 2'h2
`define LPRA_MODE_RST `LPRA_MODE_FREE

// ----------------------------------------
// Result word layout
// ----------------------------------------
`define LPRA_CNT_W 7
`define LPRA_SIG_W 16
`define LPRA_RES_W 26
`define LPRA_RES_CNT_LSB 0
`define LPRA_RES_LO_BIT 7
`define LPRA_RES_INV_BIT 8
`define LPRA_RES_HI_BIT 9
`define LPRA_RES_SIG_LSB 10
`define LPRA_CNT_RST 7'h00
`define LPRA_SIG_RST 16'h0000
`define LPRA_RES_RST 26'h0000000

// ----------------------------------------
// Timing
// ----------------------------------------
`define LPRA_CLK_PERIOD_NS 4
`define LPRA_STIM_WIDTH_NS 2000
`define LPRA_STIM_PERIOD_NS 1000000
// Sized to the timer: width and period over the clock period
`define LPRA_STIM_WIDTH_CYC 18'h001F4
`define LPRA_STIM_PERIOD_CYC 18'h3D090
`define LPRA_TMR_W 18

// ----------------------------------------
// Signature feedback taps
// ----------------------------------------
`define LPRA_SIG_POLY 16'h1021

`endif

//--- logic/lpra_sig.v
/*
  Signature register: a 16-bit cyclic check over a gated serial bit stream.
  Assumes the caller supplies a one-cycle shift strobe per sampled bit.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lpra_consts.vh"

module lpra_sig (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // Control
  input wire i_clr,
  input wire i_shift,
  input wire i_bit,
  // Result
  output wire [`LPRA_SIG_W-1:0] o_sig
);

  reg [`LPRA_SIG_W-1:0] sig_reg;
  reg [`LPRA_SIG_W-1:0] sig_next;
  reg fb;

  // ----------------------------------------
  // Next value
  // ----------------------------------------
  always @* begin
    fb = sig_reg[`LPRA_SIG_W-1] ^ i_bit;
    sig_next = sig_reg;
    if (i_clr) begin
      sig_next = `LPRA_SIG_RST;
    end else if (i_shift) begin
      // Cyclic check over the serial stream
      sig_next = {sig_reg[`LPRA_SIG_W-2:0], 1'b0} ^ (fb ? `LPRA_SIG_POLY : `LPRA_SIG_RST);
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sig_reg <= `LPRA_SIG_RST;
    end else begin
      sig_reg <= sig_next;
    end
  end

  assign o_sig = sig_reg;

endmodule // lpra_sig
`default_nettype wire

//--- dv/lpra_node_model.sv
/*
  Circuit node model at the probe tip: two threshold comparators.
  Assumes the bench sets the node level; probe drive overrides it.
*/
`timescale 1ns/1ps
`default_nettype none

module lpra_node_model (
  // Node level: 0 low, 1 invalid, 2 high
  input wire logic [1:0] i_level,
  // Probe drive
  input wire logic i_tip_out,
  input wire logic i_tip_oe,
  // Comparators
  output logic o_above_hi,
  output logic o_below_lo
);
  // Probe pulses win over the node, so the probe sees its own stimulus
  // Neither comparator high reads as invalid
  assign o_above_hi = i_tip_oe ? i_tip_out : (i_level == 2'h2);
  assign o_below_lo = i_tip_oe ? !i_tip_out : (i_level == 2'h0);
endmodule // lpra_node_model

`default_nettype wire

//--- dv/lpra_top_sva.sv
/*
  Port checker for lpra_top.
  Assumes pins pass a 2-flop synchroniser before the logic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lpra_consts.vh"

module lpra_top_sva #(
  parameter [`LPRA_TMR_W-1:0] P_STIM_PERIOD_CYC = `LPRA_STIM_PERIOD_CYC
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // Inputs
  input wire i_tip_above_hi,
  input wire i_tip_below_lo,
  input wire i_sync_valid,
  input wire i_snap,
  input wire i_mode_sel,
  input wire [`LPRA_MODE_W-1:0] i_mode,
  input wire i_stim_hi_sel,
  input wire i_stim_lo_sel,
  // Outputs
  input wire [`LPRA_RES_W-1:0] o_result0,
  input wire o_snap_done,
  input wire [`LPRA_MODE_W-1:0] o_mode,
  input wire o_ind_hi,
  input wire o_ind_lo,
  input wire o_tip_out,
  input wire o_tip_oe
);
  localparam [1:0] FREE = `LPRA_MODE_FREE;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Pulse length counter; aborted pulses are excluded below
  reg [9:0] oe_cnt_reg;
  wire [9:0] oe_cnt_next = o_tip_oe ? oe_cnt_reg + 10'h001 : 10'h000;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) oe_cnt_reg <= 10'h000;
    else oe_cnt_reg <= oe_cnt_next;
  end
  sequence s_sync_rise;
    $rose(i_sync_valid) && o_mode != FREE && (i_stim_hi_sel || i_stim_lo_sel) && !i_mode_sel;
  endsequence
  sequence s_sync_idle;
    (o_mode != FREE && !i_sync_valid)[*4];
  endsequence
  snap_answer_a: assert property (i_snap |=> o_snap_done)
    else $error("snapshot not answered");
  result_hold_a: assert property (!i_snap |=> !o_snap_done && $stable(o_result0))
    else $error("result changed without snapshot");
  mode_take_a: assert property (i_mode_sel && i_mode != 2'h3 |=> o_mode == $past(i_mode))
    else $error("mode select not taken");
  sync_inv_a: assert property (o_snap_done && $past(o_mode) != FREE |-> !o_result0[`LPRA_RES_INV_BIT])
    else $error("invalid flag set in sync mode");
  free_sig_a: assert property (o_snap_done && $past(o_mode) == FREE |-> o_result0[25:10] == 16'h0000)
    else $error("signature in free-run");
  stim_off_a: assert property (!i_stim_hi_sel && !i_stim_lo_sel |=> !o_tip_oe)
    else $error("stimulus with selects off");
  free_width_a: assert property ($fell(o_tip_oe) && $past(o_mode) == FREE && !$past(i_mode_sel)
    && $past(i_stim_hi_sel || i_stim_lo_sel) |-> oe_cnt_reg == 10'h1F4)
    else $error("free-run pulse width wrong");
  sync_start_a: assert property (s_sync_rise |-> ##[2:4] o_tip_oe)
    else $error("no pulse for valid period");
  sync_end_a: assert property ($fell(i_sync_valid) && o_mode != FREE |-> ##[2:4] !o_tip_oe)
    else $error("pulse outlives valid period");
  ind_gate_a: assert property (s_sync_idle |=> !o_ind_hi && !o_ind_lo)
    else $error("indicator outside valid period");
endmodule // lpra_top_sva

bind lpra_top lpra_top_sva #(.P_STIM_PERIOD_CYC(P_STIM_PERIOD_CYC)) u_sva (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_tip_above_hi(i_tip_above_hi), .i_tip_below_lo(i_tip_below_lo),
  .i_sync_valid(i_sync_valid), .i_snap(i_snap), .i_mode_sel(i_mode_sel), .i_mode(i_mode),
  .i_stim_hi_sel(i_stim_hi_sel), .i_stim_lo_sel(i_stim_lo_sel), .o_result0(o_result0),
  .o_snap_done(o_snap_done), .o_mode(o_mode), .o_ind_hi(o_ind_hi), .o_ind_lo(o_ind_lo),
  .o_tip_out(o_tip_out), .o_tip_oe(o_tip_oe));

`default_nettype wire

//--- dv/tb_logic_probe_response_accumulator.sv
/*
  Self-checking bench for lpra_top with a node model at the tip.
  Assumes a short stimulus frame of 1000 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lpra_consts.vh"
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin fails++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end

module tb_logic_probe_response_accumulator;
  logic i_clk, i_rst_b, i_sync_valid, i_snap, i_mode_sel, i_stim_hi_sel, i_stim_lo_sel;
  logic [1:0] i_mode;
  logic [1:0] lvl;
  logic p, p2;
  int w, t, fails = 0, n_compared = 0;
  wire logic above, below, ind_hi, ind_lo, tip_out, tip_oe, snap_done;
  wire logic [`LPRA_RES_W-1:0] res;
  wire logic [1:0] mode;

  lpra_top #(.P_STIM_PERIOD_CYC(18'h003E8)) DUT (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_tip_above_hi(above), .i_tip_below_lo(below), .i_sync_valid(i_sync_valid), .i_snap(i_snap),
    .i_mode_sel(i_mode_sel), .i_mode(i_mode), .i_stim_hi_sel(i_stim_hi_sel), .i_stim_lo_sel(i_stim_lo_sel),
    .o_result0(res), .o_snap_done(snap_done), .o_mode(mode), .o_ind_hi(ind_hi), .o_ind_lo(ind_lo),
    .o_tip_out(tip_out), .o_tip_oe(tip_oe));
  lpra_node_model u_node (.i_level(lvl), .i_tip_out(tip_out), .i_tip_oe(tip_oe),
    .o_above_hi(above), .o_below_lo(below));

  initial begin
    i_clk = 0;
    forever #2 i_clk = ~i_clk;
  end

  // ----------------------------------------
  // Drivers, all on the falling edge
  // ----------------------------------------
  task cyc(input int n); repeat (n) @(negedge i_clk); endtask
  task snap; i_snap = 1; cyc(1); i_snap = 0; `CHK("snap_done", 1'b1, snap_done) cyc(1); endtask
  task sel_mode(input logic [1:0] m);
    i_mode = m; i_mode_sel = 1; cyc(1); i_mode_sel = 0;
    `CHK("mode", m, mode)
  endtask
  // Margin of 5 cycles covers the synchroniser and count latency
  task pulses(input int n);
    repeat (n) begin lvl = 2'h2; cyc(2); lvl = 2'h0; cyc(2); end
    cyc(5);
  endtask
  task wait_pulse;
    t = 0; w = 0;
    while (!tip_oe && t < 1500) begin cyc(1); t++; end
    p = tip_out;
    while (tip_oe && w < 1500) begin cyc(1); w++; end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset; `CHK("reset mode", `LPRA_MODE_FREE, mode) $display("test reset done"); endtask
  task t_count;
    snap; pulses(3); snap;
    `CHK("count", 7'h03, res[6:0])
    `CHK("flags", 3'h5, res[9:7])
    `CHK("sig", 16'h0000, res[25:10])
    pulses(130); snap;
    `CHK("wrap", 7'h02, res[6:0])
    snap;
    `CHK("cleared", 7'h00, res[6:0])
    pulses(4); sel_mode(`LPRA_MODE_FREE); cyc(5); snap;
    `CHK("mode clear", 7'h00, res[6:0])
    $display("test count done");
  endtask
  task t_lowinv;
    snap;
    repeat (10) begin lvl = 2'h1; cyc(2); lvl = 2'h0; cyc(2); end
    cyc(5); snap;
    `CHK("no count", 7'h00, res[6:0])
    `CHK("inv lo", 3'h3, res[9:7])
    `CHK("ind lo", 1'b1, ind_lo)
    $display("test lowinv done");
  endtask
  task t_sync;
    sel_mode(`LPRA_MODE_ADDR); pulses(5); snap;
    `CHK("count", 7'h05, res[6:0])
    `CHK("flags", 3'h0, res[9:7])
    `CHK("ind", 2'h0, {ind_hi, ind_lo})
    lvl = 2'h1; i_sync_valid = 1; cyc(6); lvl = 2'h2; cyc(6);
    `CHK("ind hi", 1'b1, ind_hi)
    i_sync_valid = 0; cyc(6); snap;
    `CHK("hi only", 3'h4, res[9:7])
    `CHK("sig", `LPRA_SIG_POLY, res[25:10])
    lvl = 2'h0; cyc(5);
    $display("test sync done");
  endtask
  task t_stim_free;
    sel_mode(`LPRA_MODE_FREE); i_stim_hi_sel = 1; wait_pulse;
    `CHK("width", 500, w)
    cyc(5); snap; wait_pulse;
    `CHK("gap", 493, t)
    `CHK("high", 1'b1, p)
    cyc(5); snap;
    `CHK("own pulse", 7'h01, res[6:0])
    i_stim_hi_sel = 0; i_stim_lo_sel = 1; wait_pulse;
    `CHK("low", 1'b0, p)
    i_stim_hi_sel = 1; wait_pulse; p2 = p; wait_pulse;
    `CHK("alt", ~p2, p)
    cyc(600);
    `CHK("on", 1'b1, tip_oe)
    i_stim_hi_sel = 0; i_stim_lo_sel = 0; cyc(2);
    `CHK("off", 1'b0, tip_oe)
    $display("test stim_free done");
  endtask
  task t_stim_sync;
    sel_mode(`LPRA_MODE_DATA); i_stim_hi_sel = 1; snap; cyc(5);
    `CHK("passive", 1'b0, tip_oe)
    i_sync_valid = 1;
    fork
      begin cyc(20); i_sync_valid = 0; end
      wait_pulse;
    join
    `CHK("sync width", 20, w)
    i_stim_hi_sel = 0;
    $display("test stim_sync done");
  endtask

  task report_and_stop;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    i_rst_b = 0; i_sync_valid = 0; i_snap = 0; i_mode_sel = 0; i_mode = 2'h0;
    i_stim_hi_sel = 0; i_stim_lo_sel = 0; lvl = 2'h0;
    cyc(6); i_rst_b = 1; cyc(1);
    t_reset; t_count; t_lowinv; t_sync; t_stim_free; t_stim_sync;
    report_and_stop;
  end
  // Tests need about 6000 cycles; allow about eight times that
  initial begin
    #200000;
    fails++;
    report_and_stop;
  end
endmodule // tb_logic_probe_response_accumulator

`default_nettype wire
